// ---- core/sleep_params.svh ----
// Behaviour
// - Software picks one of five sleep modes, each gating its own set of clock domains.
// - Idle stops the CPU clock while memory, timers, serial port and interrupts keep running.
// - Power-down stops the main oscillator and every other function while registers keep state.
// - Power-down is left only on an interrupt or a hardware reset, then clocks come back.
// - Power-save keeps the asynchronous timer clocked and stops everything else.
// - Converter noise reduction keeps only the oscillator, the asynchronous timer and the converter running.
// - Standby keeps the crystal oscillator running and stops everything else.
// - Any active reset tri-states every port pin, even without a running clock.
// - Every port pin has its own pull-up enable; ports B and D are 8 bits, port C is 7.
// - With the reset-pin-disable fuse programmed the shared reset pin is a port C I/O bit.
// - With that fuse unprogrammed the shared pin is an active-low external reset input.
// - A low reset pin resets the device without a clock; the driver must hold it long enough.
// - Clock-selection fuses decide whether the two crystal pins of port B serve the amplifier.
// - With the RC oscillator and the timer clock select set, port B pins 7..6 feed the timer.
`ifndef SLEEP_PARAMS_SVH
`define SLEEP_PARAMS_SVH
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_PB_OUT 12'h008
`define OFF_PB_DIR 12'h00c
`define OFF_PC_OUT 12'h010
`define OFF_PC_DIR 12'h014
`define OFF_PD_OUT 12'h018
`define OFF_PD_DIR 12'h01c
`define OFF_PINS 12'h020
`define CTRL_SE 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 3
`define CTRL_ASYNC 4
`define STAT_EXTRF 9
`define MODE_IDLE 3'h0
`define MODE_ADC 3'h1
`define MODE_PDOWN 3'h2
`define MODE_PSAVE 3'h3
`define MODE_STANDBY 3'h6
`define GATES_RESET 5'h1f
`define RST_PIN_BIT 6
`endif

// ---- core/sleep_pkg.sv ----
`include "sleep_params.svh"
package sleep_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } state_e;
    typedef struct packed {
        logic osc;
        logic adc;
        logic async_tmr;
        logic io;
        logic cpu;
    } gates_s;
endpackage

// ---- core/pin_bank_if.sv ----
`timescale 1ns/100ps
interface pin_bank_if #(parameter int W = 8);
    logic [W-1:0] out_val;
    logic [W-1:0] dir;
    logic [W-1:0] claim;
    logic rst_active;
    logic [W-1:0] pin_val;
    modport ctrl(output out_val, output dir, output claim, output rst_active, input pin_val);
    modport bank(input out_val, input dir, input claim, input rst_active, output pin_val);
endinterface

// ---- core/pin_bank.sv ----
`timescale 1ns/100ps
module pin_bank #(parameter int W = 8) (
    input wire logic clk,
    input wire logic srst,
    pin_bank_if.bank ctl,
    input wire logic [W-1:0] pad_in,
    output logic [W-1:0] pad_out,
    output logic [W-1:0] pad_oe_n,
    output logic [W-1:0] pull_en
);
    logic [W-1:0] pin_q;

    // Reset forces the drivers off combinationally, so no clock edge is needed.
    assign pad_oe_n = {W{ctl.rst_active}} | ctl.claim | ~ctl.dir;
    assign pad_out = ctl.out_val;
    assign pull_en = ~({W{ctl.rst_active}} | ctl.claim | ctl.dir) & ctl.out_val;
    assign ctl.pin_val = pin_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_q <= '0;
        end else begin
            pin_q <= pad_in;
        end
    end

    a_reset_tristate: assert property (@(posedge clk)
        ctl.rst_active |-> (&pad_oe_n) && (pull_en == '0))
        else $error("port driven during reset");
    a_pull_per_bit: assert property (@(posedge clk) disable iff (srst)
        !ctl.rst_active |-> pull_en == (~ctl.claim & ~ctl.dir & ctl.out_val))
        else $error("pull-up enable does not follow its bit");
endmodule

// ---- core/sleep_reset_pin_control.sv ----
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "sleep_params.svh"
module sleep_reset_pin_control (
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_instr,
    input wire logic wake_irq,
    input wire logic reset_pin_disable_fuse,
    input wire logic crystal_osc_fuse,
    input wire logic rc_osc_selected,
    input wire logic [7:0] portb_in,
    output logic [7:0] portb_out,
    output logic [7:0] portb_oe_n,
    output logic [7:0] portb_pull_en,
    input wire logic [6:0] portc_in,
    output logic [6:0] portc_out,
    output logic [6:0] portc_oe_n,
    output logic [6:0] portc_pull_en,
    input wire logic [7:0] portd_in,
    output logic [7:0] portd_out,
    output logic [7:0] portd_oe_n,
    output logic [7:0] portd_pull_en,
    output logic cpu_clk_en,
    output logic io_clk_en,
    output logic async_clk_en,
    output logic adc_clk_en,
    output logic osc_en,
    output logic internal_reset,
    output logic osc_amp_pins_en,
    output logic timer_osc_pins_en
);
    sleep_pkg::state_e state_q;
    sleep_pkg::state_e state_d;
    sleep_pkg::gates_s gates_q;
    sleep_pkg::gates_s gates_d;
    logic sleep_en_q;
    logic [2:0] mode_sel_q;
    logic [2:0] active_mode_q;
    logic async_timer_clock_select_q;
    logic mode_ok;
    logic [7:0] pb_out_q;
    logic [7:0] pb_dir_q;
    logic [6:0] pc_out_q;
    logic [6:0] pc_dir_q;
    logic [7:0] pd_out_q;
    logic [7:0] pd_dir_q;
    logic ext_rst_req;
    logic [1:0] rst_sync_q;
    logic rst_int;
    logic rst_active;
    logic ext_rst_flag_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic hit;
    logic wr_en;
    logic setup;
    logic [31:0] status;
    logic timer_pins;

    pin_bank_if #(.W(8)) pb_if();
    pin_bank_if #(.W(7)) pc_if();
    pin_bank_if #(.W(8)) pd_if();

    // The reset request is taken from the pad itself, so it acts with no clock.
    assign ext_rst_req = ~reset_pin_disable_fuse & ~portc_in[`RST_PIN_BIT];

    // Assertion is immediate; release waits two edges so no flop sees a runt edge.
    always_ff @(posedge clk or posedge ext_rst_req) begin
        if (ext_rst_req) begin
            rst_sync_q <= 2'b11;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b0};
        end
    end

    assign rst_int = srst | rst_sync_q[1];
    assign rst_active = srst | ext_rst_req | rst_sync_q[1];
    assign internal_reset = rst_int;

    // Crystal pins leave the port when the fuses or the timer select claim them.
    assign osc_amp_pins_en = crystal_osc_fuse;
    assign timer_pins = ~crystal_osc_fuse & rc_osc_selected & async_timer_clock_select_q;
    assign timer_osc_pins_en = timer_pins;

    assign pb_if.out_val = pb_out_q;
    assign pb_if.dir = pb_dir_q;
    assign pb_if.claim = {{2{osc_amp_pins_en | timer_pins}}, 6'h00};
    assign pb_if.rst_active = rst_active;
    assign pc_if.out_val = pc_out_q;
    assign pc_if.dir = pc_dir_q;
    assign pc_if.claim = {~reset_pin_disable_fuse, 6'h00};
    assign pc_if.rst_active = rst_active;
    assign pd_if.out_val = pd_out_q;
    assign pd_if.dir = pd_dir_q;
    assign pd_if.claim = 8'h00;
    assign pd_if.rst_active = rst_active;

    pin_bank #(.W(8)) u_portb (
        .clk(clk),
        .srst(rst_int),
        .ctl(pb_if.bank),
        .pad_in(portb_in),
        .pad_out(portb_out),
        .pad_oe_n(portb_oe_n),
        .pull_en(portb_pull_en)
    );
    pin_bank #(.W(7)) u_portc (
        .clk(clk),
        .srst(rst_int),
        .ctl(pc_if.bank),
        .pad_in(portc_in),
        .pad_out(portc_out),
        .pad_oe_n(portc_oe_n),
        .pull_en(portc_pull_en)
    );
    pin_bank #(.W(8)) u_portd (
        .clk(clk),
        .srst(rst_int),
        .ctl(pd_if.bank),
        .pad_in(portd_in),
        .pad_out(portd_out),
        .pad_oe_n(portd_oe_n),
        .pull_en(portd_pull_en)
    );

    // Reserved mode codes are refused, so a stray write cannot freeze the part.
    always_comb begin
        case (mode_sel_q)
            `MODE_IDLE, `MODE_ADC, `MODE_PDOWN, `MODE_PSAVE, `MODE_STANDBY: mode_ok = 1'b1;
            default: mode_ok = 1'b0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            sleep_pkg::ST_RUN: begin
                if (sleep_instr && sleep_en_q && mode_ok) begin
                    state_d = sleep_pkg::ST_SLEEP;
                end
            end
            sleep_pkg::ST_SLEEP: begin
                if (wake_irq) begin
                    state_d = sleep_pkg::ST_WAKE;
                end
            end
            sleep_pkg::ST_WAKE: state_d = sleep_pkg::ST_RUN;
            default: state_d = sleep_pkg::ST_RUN;
        endcase
    end

    // A hardware reset always lands in the run state with every clock on.
    always_ff @(posedge clk) begin
        if (rst_int) begin
            state_q <= sleep_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            active_mode_q <= `MODE_IDLE;
        end else if (state_q == sleep_pkg::ST_RUN && state_d == sleep_pkg::ST_SLEEP) begin
            active_mode_q <= mode_sel_q;
        end
    end

    // Gates follow the next state so they change on the same edge as the state.
    always_comb begin
        gates_d = `GATES_RESET;
        case (state_d)
            sleep_pkg::ST_RUN: gates_d = `GATES_RESET;
            sleep_pkg::ST_WAKE: gates_d = 5'h1e;
            sleep_pkg::ST_SLEEP: begin
                case ((state_q == sleep_pkg::ST_SLEEP) ? active_mode_q : mode_sel_q)
                    `MODE_IDLE: gates_d = 5'h1e;
                    `MODE_ADC: gates_d = 5'h1c;
                    `MODE_PDOWN: gates_d = 5'h00;
                    `MODE_PSAVE: gates_d = 5'h04;
                    `MODE_STANDBY: gates_d = 5'h10;
                    default: gates_d = `GATES_RESET;
                endcase
            end
            default: gates_d = `GATES_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            gates_q <= `GATES_RESET;
        end else begin
            gates_q <= gates_d;
        end
    end

    assign cpu_clk_en = gates_q.cpu;
    assign io_clk_en = gates_q.io;
    assign async_clk_en = gates_q.async_tmr;
    assign adc_clk_en = gates_q.adc;
    assign osc_en = gates_q.osc;

    // APB: zero wait states; read data and decode are captured in the setup cycle.
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = psel & penable & err_q;

    assign status = {19'h0, timer_pins, osc_amp_pins_en, reset_pin_disable_fuse,
                     ext_rst_flag_q, gates_q, active_mode_q, state_q == sleep_pkg::ST_SLEEP};

    always_comb begin
        hit = 1'b1;
        rdata_d = 32'h0;
        case (paddr)
            `OFF_CTRL: rdata_d = {27'h0, async_timer_clock_select_q, mode_sel_q, sleep_en_q};
            `OFF_STATUS: rdata_d = status;
            `OFF_PB_OUT: rdata_d = {24'h0, pb_out_q};
            `OFF_PB_DIR: rdata_d = {24'h0, pb_dir_q};
            `OFF_PC_OUT: rdata_d = {25'h0, pc_out_q};
            `OFF_PC_DIR: rdata_d = {25'h0, pc_dir_q};
            `OFF_PD_OUT: rdata_d = {24'h0, pd_out_q};
            `OFF_PD_DIR: rdata_d = {24'h0, pd_dir_q};
            `OFF_PINS: rdata_d = {9'h0, pd_if.pin_val, pc_if.pin_val, pb_if.pin_val};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            prdata_q <= 32'h0;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0 : rdata_d;
            err_q <= ~hit;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            sleep_en_q <= 1'b0;
            mode_sel_q <= `MODE_IDLE;
            async_timer_clock_select_q <= 1'b0;
        end else if (wr_en && paddr == `OFF_CTRL) begin
            sleep_en_q <= pwdata[`CTRL_SE];
            mode_sel_q <= pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
            async_timer_clock_select_q <= pwdata[`CTRL_ASYNC];
        end
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            pb_out_q <= 8'h00;
            pb_dir_q <= 8'h00;
            pc_out_q <= 7'h00;
            pc_dir_q <= 7'h00;
            pd_out_q <= 8'h00;
            pd_dir_q <= 8'h00;
        end else if (wr_en) begin
            case (paddr)
                `OFF_PB_OUT: pb_out_q <= pwdata[7:0];
                `OFF_PB_DIR: pb_dir_q <= pwdata[7:0];
                `OFF_PC_OUT: pc_out_q <= pwdata[6:0];
                `OFF_PC_DIR: pc_dir_q <= pwdata[6:0];
                `OFF_PD_OUT: pd_out_q <= pwdata[7:0];
                `OFF_PD_DIR: pd_dir_q <= pwdata[7:0];
                default: pb_out_q <= pb_out_q;
            endcase
        end
    end

    // Of the resets only the plain synchronous reset clears this flag, or it would erase itself.
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_rst_flag_q <= 1'b0;
        end else if (rst_sync_q[1]) begin
            ext_rst_flag_q <= 1'b1;
        end else if (wr_en && paddr == `OFF_STATUS && pwdata[`STAT_EXTRF]) begin
            ext_rst_flag_q <= 1'b0;
        end
    end

    a_idle_cpu_gate: assert property (@(posedge clk) disable iff (rst_int)
        state_q == sleep_pkg::ST_SLEEP && active_mode_q == `MODE_IDLE
        |-> !cpu_clk_en && io_clk_en && osc_en)
        else $error("idle gating wrong");
    a_pdown_all_off: assert property (@(posedge clk) disable iff (rst_int)
        state_q == sleep_pkg::ST_SLEEP && active_mode_q == `MODE_PDOWN
        |-> !osc_en && !io_clk_en && !async_clk_en && !adc_clk_en && !cpu_clk_en)
        else $error("power-down left a clock on");
    a_wake_resume: assert property (@(posedge clk) disable iff (rst_int)
        state_q == sleep_pkg::ST_SLEEP && wake_irq |=> osc_en && !cpu_clk_en ##1 cpu_clk_en)
        else $error("wake did not restore clocks");
    a_psave_timer: assert property (@(posedge clk) disable iff (rst_int)
        state_q == sleep_pkg::ST_SLEEP && active_mode_q == `MODE_PSAVE
        |-> async_clk_en && !osc_en && !io_clk_en && !cpu_clk_en)
        else $error("power-save gating wrong");
    a_adc_mode_gate: assert property (@(posedge clk) disable iff (rst_int)
        state_q == sleep_pkg::ST_SLEEP && active_mode_q == `MODE_ADC
        |-> adc_clk_en && async_clk_en && !io_clk_en && !cpu_clk_en)
        else $error("noise reduction gating wrong");
    a_standby_osc: assert property (@(posedge clk) disable iff (rst_int)
        state_q == sleep_pkg::ST_SLEEP && active_mode_q == `MODE_STANDBY
        |-> osc_en && !io_clk_en && !async_clk_en && !cpu_clk_en)
        else $error("standby gating wrong");
    a_sleep_needs_se: assert property (@(posedge clk) disable iff (rst_int)
        state_q == sleep_pkg::ST_RUN && !(sleep_instr && sleep_en_q && mode_ok)
        |=> state_q == sleep_pkg::ST_RUN && cpu_clk_en)
        else $error("sleep entered without enable");
    a_reset_release: assert property (@(posedge clk) disable iff (srst)
        $fell(ext_rst_req) |-> rst_int ##1 rst_int)
        else $error("reset released too early");
    a_reset_pin_role: assert property (@(posedge clk) disable iff (srst)
        !reset_pin_disable_fuse |-> portc_oe_n[`RST_PIN_BIT] && !portc_pull_en[`RST_PIN_BIT])
        else $error("reset pin driven as port bit");
    a_gpio_reset_pin: assert property (@(posedge clk) disable iff (rst_int)
        reset_pin_disable_fuse && pc_dir_q[`RST_PIN_BIT]
        |-> !portc_oe_n[`RST_PIN_BIT])
        else $error("shared pin not usable as port bit");
    a_timer_pins: assert property (@(posedge clk) disable iff (rst_int)
        timer_pins || crystal_osc_fuse |-> portb_oe_n[7:6] == 2'b11)
        else $error("crystal pins still driven by port");

    // The pad request alone must float the ports, before any clock edge reaches the sync.
    a_ext_reset_float: assert property (@(posedge clk)
        ext_rst_req |-> (&portb_oe_n) && (&portc_oe_n) && (&portd_oe_n))
        else $error("port driven during external reset");
    a_ext_flag_set: assert property (@(posedge clk) disable iff (srst)
        rst_sync_q[1] |=> ext_rst_flag_q)
        else $error("external reset not recorded");
    // Only an interrupt or a reset may end sleep; anything else would be a silent wake.
    a_sleep_holds: assert property (@(posedge clk) disable iff (rst_int)
        state_q == sleep_pkg::ST_SLEEP && !wake_irq |=> state_q == sleep_pkg::ST_SLEEP)
        else $error("sleep left without a wake source");
endmodule

// ---- verification/reset_wake_source.sv ----
`timescale 1ns/100ps
module reset_wake_source #(parameter int MIN_LOW = 4) (
    input wire logic clk,
    output logic rst_pin,
    output logic wake_irq
);
    // The shared pin has a pull-up, so a released line reads high.
    initial begin
        rst_pin = 1'b1;
        wake_irq = 1'b0;
    end
    // Shorter lows are not guaranteed to reset, so the source never sends them.
    task automatic hold_reset();
        @(posedge clk);
        rst_pin <= 1'b0;
        repeat (MIN_LOW) @(posedge clk);
        rst_pin <= 1'b1;
    endtask
    task automatic wake();
        @(posedge clk);
        wake_irq <= 1'b1;
        @(posedge clk);
        wake_irq <= 1'b0;
    endtask
endmodule

// ---- verification/sleep_reset_pin_control_tb_top.sv ----
`timescale 1ns/100ps
`include "sleep_params.svh"
module sleep_reset_pin_control_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic sleep_instr = 1'b0;
    logic fuse = 1'b0;
    logic xtal = 1'b0;
    logic rc = 1'b0;
    logic [22:0] pad = 23'h000000;
    logic rst_pin;
    logic wake_irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Nets, since several ports of the design drive slices of each.
    wire [22:0] pout;
    wire [22:0] oe_n;
    wire [22:0] pull;
    wire [4:0] gates;
    logic internal_reset;
    logic amp_en;
    logic tmr_en;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    integer seed = 15;
    int regs[9];
    logic [31:0] rd;
    logic err;

    always #10 clk = ~clk;

    reset_wake_source src (.clk(clk), .rst_pin(rst_pin), .wake_irq(wake_irq));

    sleep_reset_pin_control dut (
        .clk(clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_instr(sleep_instr), .wake_irq(wake_irq),
        .reset_pin_disable_fuse(fuse), .crystal_osc_fuse(xtal), .rc_osc_selected(rc),
        .portb_in(pad[7:0]), .portb_out(pout[7:0]), .portb_oe_n(oe_n[7:0]),
        .portb_pull_en(pull[7:0]), .portc_in({rst_pin, pad[13:8]}),
        .portc_out(pout[14:8]), .portc_oe_n(oe_n[14:8]), .portc_pull_en(pull[14:8]),
        .portd_in(pad[22:15]), .portd_out(pout[22:15]), .portd_oe_n(oe_n[22:15]),
        .portd_pull_en(pull[22:15]), .cpu_clk_en(gates[0]), .io_clk_en(gates[1]),
        .async_clk_en(gates[2]), .adc_clk_en(gates[3]), .osc_en(gates[4]),
        .internal_reset(internal_reset), .osc_amp_pins_en(amp_en),
        .timer_osc_pins_en(tmr_en)
    );

    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic int msk(input logic [11:0] a);
        if (a == `OFF_CTRL) return 32'h0000001f;
        if (a == `OFF_PC_OUT || a == `OFF_PC_DIR) return 32'h0000007f;
        return 32'h000000ff;
    endfunction

    // Zero wait states are expected, yet the wait only ends on pready.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a != `OFF_STATUS && a < `OFF_PINS) regs[a >> 2] = d & msk(a);
    endtask

    task automatic rdchk(input logic [11:0] a);
        apb(1'b0, a, 32'h00000000);
        chk(rd, regs[a >> 2]);
    endtask

    task automatic pins_chk();
        logic [22:0] dir;
        logic [22:0] out;
        logic [22:0] cl;
        logic [22:0] oe;
        logic amp;
        @(posedge clk);
        #1;
        amp = xtal | (rc & regs[0][4]);
        dir = {regs[7][7:0], regs[5][6:0], regs[3][7:0]};
        out = {regs[6][7:0], regs[4][6:0], regs[2][7:0]};
        cl = {8'h00, ~fuse, 6'h00, amp, amp, 6'h00};
        // Sized here, or the inverse would be widened to 32 bits with 9 leading ones before the compare.
        oe = ~dir | cl;
        chk(oe_n, oe);
        chk(pull, ~dir & out & ~cl);
        chk(pout, out);
        chk(amp_en, xtal);
        chk(tmr_en, ~xtal & rc & regs[0][4]);
    endtask

    function automatic logic [4:0] gexp(input logic [2:0] m, input logic se);
        if (!se) return 5'h1f;
        case (m)
            `MODE_IDLE: return 5'h1e;
            `MODE_ADC: return 5'h1c;
            `MODE_PDOWN: return 5'h00;
            `MODE_PSAVE: return 5'h04;
            `MODE_STANDBY: return 5'h10;
            default: return 5'h1f;
        endcase
    endfunction

    task automatic sleep_chk(input logic [2:0] m, input logic se);
        logic [4:0] e;
        e = gexp(m, se);
        wr(`OFF_CTRL, {28'h0, m, se});
        @(posedge clk);
        sleep_instr <= 1'b1;
        @(posedge clk);
        sleep_instr <= 1'b0;
        #1;
        chk(gates, e);
        repeat (3) @(posedge clk);
        #1;
        chk(gates, e);
        if (e != 5'h1f) begin
            src.wake();
            #1;
            chk(gates, 5'h1e);
            @(posedge clk);
            #1;
            chk(gates, 5'h1f);
        end
    endtask

    task automatic ext_rst(input logic gpio);
        fork
            src.hold_reset();
            begin
                @(posedge clk);
                #1;
                chk(internal_reset, !gpio);
                if (!gpio) chk(oe_n, 32'h007fffff);
            end
        join
        @(posedge clk);
        #1;
        chk(internal_reset, !gpio);
        repeat (2) @(posedge clk);
        #1;
        chk(internal_reset, 1'b0);
    endtask

    initial begin
        repeat (7) @(posedge clk);
        #1;
        chk(oe_n, 32'h007fffff);
        chk(pull, 32'h00000000);
        chk(gates, 5'h1f);
        @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 32; a += 4) if (a != 4) rdchk(a[11:0]);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {fuse, xtal, rc} <= i[2:0];
            wr(`OFF_CTRL, $random(seed));
            for (int a = 8; a < 32; a += 4) wr(a[11:0], $random(seed));
            for (int a = 0; a < 32; a += 4) if (a != 4) rdchk(a[11:0]);
            pins_chk();
        end
        @(posedge clk);
        pad <= 23'($random(seed));
        apb(1'b0, `OFF_PINS, 32'h00000000);
        chk(rd, {9'h000, pad[22:15], rst_pin, pad[13:0]});
        apb(1'b1, 12'h040, 32'hffffffff);
        chk(err, 1'b1);
        apb(1'b0, 12'h040, 32'h00000000);
        chk(err, 1'b1);
        chk(rd, 32'h00000000);
        @(posedge clk);
        {fuse, xtal, rc} <= 3'h0;
        for (int m = 0; m < 8; m++) sleep_chk(m[2:0], 1'b1);
        sleep_chk(`MODE_PDOWN, 1'b0);
        wr(`OFF_PB_DIR, 32'h000000ff);
        ext_rst(1'b0);
        for (int k = 0; k < 9; k++) regs[k] = 0;
        rdchk(`OFF_PB_DIR);
        pins_chk();
        apb(1'b0, `OFF_STATUS, 32'h00000000);
        chk(rd & 32'h00001ff0, 32'h000003f0);
        apb(1'b1, `OFF_STATUS, 32'h00000200);
        apb(1'b0, `OFF_STATUS, 32'h00000000);
        chk(rd & 32'h00000200, 32'h00000000);
        @(posedge clk);
        fuse <= 1'b1;
        wr(`OFF_PC_DIR, 32'h00000040);
        ext_rst(1'b1);
        pins_chk();
        test_done();
    end
endmodule
